// ---- hdl/rocc_defs.vh ----
`ifndef ROCC_DEFS_VH
`define ROCC_DEFS_VH
// register byte offsets
`define ROCC_OFS_RING      8'h00
`define ROCC_OFS_XTAL      8'h04
`define ROCC_OFS_PLL       8'h08
`define ROCC_OFS_PLLDIV    8'h0C
`define ROCC_OFS_PROCMON   8'hF0
// ring oscillator register fields
`define ROCC_DIV_LSB       0
`define ROCC_DIV_MSB       5
`define ROCC_TRIM_LSB      16
`define ROCC_TRIM_MSB      20
`define ROCC_EN_BIT        30
`define ROCC_RDY_BIT       31
`define ROCC_DIV_RST       6'h04
`define ROCC_TRIM_RST      5'h10
// crystal oscillator register fields
`define ROCC_XEN_BIT       30
`define ROCC_XRDY_BIT      31
// pll register fields and resets
`define ROCC_PLLR_MSB      2
`define ROCC_PLLF_LSB      4
`define ROCC_PLLF_MSB      9
`define ROCC_PLLQ_LSB      10
`define ROCC_PLLQ_MSB      11
`define ROCC_PSEL_BIT      16
`define ROCC_PREF_BIT      17
`define ROCC_PBYP_BIT      18
`define ROCC_LOCK_BIT      31
`define ROCC_PLLR_RST      3'h1
`define ROCC_PLLF_RST      6'h1F
`define ROCC_PLLQ_RST      2'h3
// final divider and process monitor
`define ROCC_ODIV_MSB      5
`define ROCC_ODIV_RST      6'h00
`define ROCC_PMON_RST      32'h0000_0000
// cycles from enable until the ring reports ready
`define ROCC_RDY_CYCLES    8'h10
`endif

// ---- hdl/rocc_ring_div.v ----
`timescale 1ns/1ns
`include "rocc_defs.vh"
// integer divider: one output tick every (ratio+1) input ticks
module rocc_ring_div
#(
  parameter W = 6
)
(
  input  wire         clk_i,
  input  wire         rst_i,
  input  wire         run_i,
  input  wire [W-1:0] ratio_i,
  output reg          tick_o
);
  reg [W-1:0] cnt_q;

  // a new ratio is compared at once; a count already at or above it wraps on the next cycle
  always @(posedge clk_i)
  begin
    if (rst_i || !run_i)
    begin
      cnt_q  <= {W{1'b0}};
      tick_o <= 1'b0;
    end
    else if (cnt_q >= ratio_i)
    begin
      cnt_q  <= {W{1'b0}};
      tick_o <= 1'b1;
    end
    else
    begin
      cnt_q  <= cnt_q + {{(W-1){1'b0}}, 1'b1};
      tick_o <= 1'b0;
    end
  end
endmodule // rocc_ring_div

// ---- hdl/rocc_sync.v ----
`timescale 1ns/1ns
// two flip-flop synchroniser for a level from another domain
module rocc_sync
(
  input  wire clk_i,
  input  wire rst_i,
  input  wire d_i,
  output wire q_o
);
  reg meta_q;
  reg sync_q;

  // first stage feeds only the second
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end
    else
    begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule // rocc_sync

// ---- hdl/rocc_top.v ----
// Overview of operation
// - fast clock from pll, ring, or crystal
// - bus shares the core clock
// - rtc picks external or internal slow oscillator
// - registers meant for machine-privilege access only
// - decode offsets 00, 04, 08, 0C, F0
// - ring oscillator drives core after reset
// - five-bit trim picks delay-chain tap
// - ring output divided by field plus one
// - divider writable at any time
// - reset loads trim 16, divider 4
// - trim writable at any time
// - enable bit stops and restarts ring
// - every reset sets enable back to one
// - ready bit shows ring usable
// - pll select routes pll to fast clock
`timescale 1ns/1ns
`include "rocc_defs.vh"
module rocc_top
(
  input  wire        clk_i,
  input  wire        rst_i,
  // apb slave
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [7:0]  paddr_i,
  input  wire [31:0] pwdata_i,
  input  wire        pprot_i,
  output reg  [31:0] prdata_o,
  output reg         pready_o,
  output reg         pslverr_o,
  // status pins from analog blocks
  input  wire        xtal_rdy_i,
  input  wire        pll_lock_i,
  input  wire        rtc_ext_sel_i,
  // analog controls
  output reg  [4:0]  ring_trim_o,
  output reg         ring_en_o,
  output reg  [5:0]  ring_div_o,
  output reg         ring_tick_o,
  output reg         ring_rdy_o,
  output reg         xtal_en_o,
  output reg  [2:0]  pll_r_o,
  output reg  [5:0]  pll_f_o,
  output reg  [1:0]  pll_q_o,
  output reg         pll_ref_sel_o,
  output reg         pll_bypass_o,
  output reg  [5:0]  pll_out_div_o,
  output reg         fast_src_pll_o,
  output reg         core_src_ring_o,
  output reg         rtc_src_ext_o,
  output reg  [31:0] procmon_o
);
  // ************************************************************
  // synchronised status inputs
  // ************************************************************
  wire xtal_rdy_s;
  wire pll_lock_s;
  wire rtc_ext_s;

  // each analog status level passes two flops before any logic reads it
  rocc_sync u_sync_xtal
  (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (xtal_rdy_i),
    .q_o   (xtal_rdy_s)
  );

  rocc_sync u_sync_lock
  (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (pll_lock_i),
    .q_o   (pll_lock_s)
  );

  rocc_sync u_sync_rtc
  (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (rtc_ext_sel_i),
    .q_o   (rtc_ext_s)
  );

  // ************************************************************
  // apb access decode
  // ************************************************************
  // address decode and the write strobe of the register bus
  wire       acc      = psel_i && penable_i;
  wire       priv_ok  = pprot_i;
  wire       hit_ring = (paddr_i == `ROCC_OFS_RING);
  wire       hit_xtal = (paddr_i == `ROCC_OFS_XTAL);
  wire       hit_pll  = (paddr_i == `ROCC_OFS_PLL);
  wire       hit_odiv = (paddr_i == `ROCC_OFS_PLLDIV);
  wire       hit_pmon = (paddr_i == `ROCC_OFS_PROCMON);
  wire       hit_any  = hit_ring | hit_xtal | hit_pll | hit_odiv | hit_pmon;
  wire       wr_ok    = acc && pwrite_i && priv_ok && pready_o;  // lands with the answer

  // start-up counter and ready flag of the ring
  reg  [7:0] rdy_cnt_q;
  reg        rdy_q;

  // ************************************************************
  // control registers
  // ************************************************************
  // ring oscillator fields; every reset restores a running ring
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ring_div_o  <= `ROCC_DIV_RST;
      ring_trim_o <= `ROCC_TRIM_RST;
      ring_en_o   <= 1'b1;
    end
    else if (wr_ok && hit_ring)
    begin
      ring_div_o  <= pwdata_i[`ROCC_DIV_MSB:`ROCC_DIV_LSB];
      ring_trim_o <= pwdata_i[`ROCC_TRIM_MSB:`ROCC_TRIM_LSB];
      ring_en_o   <= pwdata_i[`ROCC_EN_BIT];
    end
  end

  // crystal enable; the crystal itself lives outside this block
  always @(posedge clk_i)
  begin
    if (rst_i)
      xtal_en_o <= 1'b1;
    else if (wr_ok && hit_xtal)
      xtal_en_o <= pwdata_i[`ROCC_XEN_BIT];
  end

  // pll controls; select stays clear after reset so the ring keeps the core
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pll_r_o        <= `ROCC_PLLR_RST;
      pll_f_o        <= `ROCC_PLLF_RST;
      pll_q_o        <= `ROCC_PLLQ_RST;
      pll_ref_sel_o  <= 1'b1;
      pll_bypass_o   <= 1'b1;
      fast_src_pll_o <= 1'b0;
    end
    else if (wr_ok && hit_pll)
    begin
      pll_r_o        <= pwdata_i[`ROCC_PLLR_MSB:0];
      pll_f_o        <= pwdata_i[`ROCC_PLLF_MSB:`ROCC_PLLF_LSB];
      pll_q_o        <= pwdata_i[`ROCC_PLLQ_MSB:`ROCC_PLLQ_LSB];
      fast_src_pll_o <= pwdata_i[`ROCC_PSEL_BIT];
      pll_ref_sel_o  <= pwdata_i[`ROCC_PREF_BIT];
      pll_bypass_o   <= pwdata_i[`ROCC_PBYP_BIT];
    end
  end

  // final divider of the pll output
  always @(posedge clk_i)
  begin
    if (rst_i)
      pll_out_div_o <= `ROCC_ODIV_RST;
    else if (wr_ok && hit_odiv)
      pll_out_div_o <= pwdata_i[`ROCC_ODIV_MSB:0];
  end

  // process monitor word, plain storage
  always @(posedge clk_i)
  begin
    if (rst_i)
      procmon_o <= `ROCC_PMON_RST;
    else if (wr_ok && hit_pmon)
      procmon_o <= pwdata_i;
  end

  // ************************************************************
  // ring start-up model and ready flag
  // ************************************************************
  // ready only after a fixed start-up time, dropped as soon as disabled
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rdy_cnt_q <= 8'h00;
      rdy_q     <= 1'b0;
    end
    else if (!ring_en_o)
    begin
      rdy_cnt_q <= 8'h00;
      rdy_q     <= 1'b0;
    end
    else if (rdy_cnt_q == `ROCC_RDY_CYCLES)
      rdy_q <= 1'b1;
    else
      rdy_cnt_q <= rdy_cnt_q + 8'h01;
  end

  // ************************************************************
  // divided ring clock enable tick
  // ************************************************************
  wire tick_w;

  // divider width follows the field, so counter and field always agree
  localparam DIV_W = `ROCC_DIV_MSB - `ROCC_DIV_LSB + 1;

  // one tick per divide period while the ring is ready
  rocc_ring_div #(.W(DIV_W)) u_div
  (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .run_i   (rdy_q),
    .ratio_i (ring_div_o),
    .tick_o  (tick_w)
  );

  // ************************************************************
  // source selection outputs
  // ************************************************************
  // registered copies of the selects, so every output leaves a flop
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ring_tick_o     <= 1'b0;
      ring_rdy_o      <= 1'b0;
      core_src_ring_o <= 1'b1;
      rtc_src_ext_o   <= 1'b0;
    end
    else
    begin
      ring_tick_o     <= tick_w;
      ring_rdy_o      <= rdy_q;
      core_src_ring_o <= !fast_src_pll_o;
      rtc_src_ext_o   <= rtc_ext_s;
    end
  end

  // ************************************************************
  // apb read data and handshake
  // ************************************************************
  reg [31:0] rd_d;

  // read mux; reserved bits stay zero
  always @*
  begin
    rd_d = 32'h0000_0000;
    if (hit_ring)
    begin
      rd_d[`ROCC_DIV_MSB:`ROCC_DIV_LSB]   = ring_div_o;
      rd_d[`ROCC_TRIM_MSB:`ROCC_TRIM_LSB] = ring_trim_o;
      rd_d[`ROCC_EN_BIT]                  = ring_en_o;
      rd_d[`ROCC_RDY_BIT]                 = rdy_q;
    end
    if (hit_xtal)
    begin
      rd_d[`ROCC_XEN_BIT]  = xtal_en_o;
      rd_d[`ROCC_XRDY_BIT] = xtal_rdy_s & xtal_en_o;
    end
    if (hit_pll)
    begin
      rd_d[`ROCC_PLLR_MSB:0]              = pll_r_o;
      rd_d[`ROCC_PLLF_MSB:`ROCC_PLLF_LSB] = pll_f_o;
      rd_d[`ROCC_PLLQ_MSB:`ROCC_PLLQ_LSB] = pll_q_o;
      rd_d[`ROCC_PSEL_BIT]                = fast_src_pll_o;
      rd_d[`ROCC_PREF_BIT]                = pll_ref_sel_o;
      rd_d[`ROCC_PBYP_BIT]                = pll_bypass_o;
      rd_d[`ROCC_LOCK_BIT]                = pll_lock_s;
    end
    if (hit_odiv)
      rd_d[`ROCC_ODIV_MSB:0] = pll_out_div_o;
    if (hit_pmon)
      rd_d = procmon_o;
  end

  // one wait state: pready rises the cycle after penable
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end
    else if (acc && !pready_o)
    begin
      pready_o  <= 1'b1;
      pslverr_o <= !hit_any || !priv_ok;
    end
    else
    begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end
  end

  // read data is captured once per access and then held
  always @(posedge clk_i)
  begin
    if (rst_i)
      prdata_o <= 32'h0000_0000;
    else if (acc && !pready_o)
      prdata_o <= (!pwrite_i && priv_ok) ? rd_d : 32'h0000_0000;
  end
endmodule // rocc_top

// ---- sim/ring_oscillator_clock_control_test.sv ----
`timescale 1ns/1ns
// ****************
// testbench
// ****************
module ring_oscillator_clock_control_test;
  reg         clk_i, rst_i, psel_i, penable_i, pwrite_i, pprot_i;
  reg         xtal_rdy_i, pll_lock_i, rtc_ext_sel_i;
  reg  [7:0]  paddr_i;
  reg  [31:0] pwdata_i, rd;
  reg         er;
  wire [31:0] prdata_o, procmon_o;
  wire        pready_o, pslverr_o, ring_en_o, ring_tick_o, ring_rdy_o, xtal_en_o;
  wire        pll_ref_sel_o, pll_bypass_o, fast_src_pll_o, core_src_ring_o, rtc_src_ext_o;
  wire [4:0]  ring_trim_o;
  wire [5:0]  ring_div_o, pll_f_o, pll_out_div_o;
  wire [2:0]  pll_r_o;
  wire [1:0]  pll_q_o;
  integer     failures, checked;

  rocc_top dut
  (
    .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pprot_i(pprot_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .xtal_rdy_i(xtal_rdy_i), .pll_lock_i(pll_lock_i),
    .rtc_ext_sel_i(rtc_ext_sel_i), .ring_trim_o(ring_trim_o), .ring_en_o(ring_en_o),
    .ring_div_o(ring_div_o), .ring_tick_o(ring_tick_o), .ring_rdy_o(ring_rdy_o),
    .xtal_en_o(xtal_en_o), .pll_r_o(pll_r_o), .pll_f_o(pll_f_o), .pll_q_o(pll_q_o),
    .pll_ref_sel_o(pll_ref_sel_o), .pll_bypass_o(pll_bypass_o), .pll_out_div_o(pll_out_div_o),
    .fast_src_pll_o(fast_src_pll_o), .core_src_ring_o(core_src_ring_o),
    .rtc_src_ext_o(rtc_src_ext_o), .procmon_o(procmon_o)
  );

  // free running clock
  initial
  begin
    clk_i = 0;
    forever #4 clk_i = ~clk_i;
  end

  task finish_test;
    begin
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask

  task chk(input [31:0] e, input [31:0] g, input [8*6:1] nm);
    begin
      checked = checked + 1;
      if (g !== e)
      begin
        failures = failures + 1;
        $display("ERROR %0s exp %h got %h", nm, e, g);
      end
    end
  endtask

  // one apb transfer, answer taken at the edge that sees pready
  task apb(input w, input [7:0] a, input [31:0] d, input p);
    integer n;
    begin
      @(posedge clk_i);
      psel_i <= 1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      pprot_i <= p;
      @(posedge clk_i);
      penable_i <= 1;
      n = 0;
      @(posedge clk_i);
      while (!pready_o && n < 20)
      begin
        @(posedge clk_i);
        n = n + 1;
      end
      if (n == 20)
      begin
        failures = failures + 1;
        finish_test;
      end
      rd = prdata_o;
      er = pslverr_o;
      psel_i <= 0;
      penable_i <= 0;
      @(posedge clk_i);
    end
  endtask

  // cycles between two ring ticks
  task per(input [31:0] e);
    integer c, k;
    begin
      for (k = 0; k < 2; k = k + 1)
      begin
        c = 0;
        @(negedge clk_i);
        while (!ring_tick_o && c < 99)
        begin
          @(negedge clk_i);
          c = c + 1;
        end
        if (c == 99)
        begin
          failures = failures + 1;
          finish_test;
        end
      end
      chk(e, c + 1, "tick");
    end
  endtask

  task t_reset;
    begin
      repeat (20) @(posedge clk_i);
      apb(0, 8'h00, 0, 1); chk(32'hC010_0004, rd, "ring");
      apb(0, 8'h04, 0, 1); chk(32'h4000_0000, rd, "xtal");
      apb(0, 8'h08, 0, 1); chk(32'h0006_0DF1, rd, "pll");
      apb(0, 8'h0C, 0, 1); chk(32'h0000_0000, rd, "odiv");
      chk(1, core_src_ring_o, "core");
      chk(32'h0000_1EF9, {pll_bypass_o, pll_ref_sel_o, pll_q_o, pll_f_o, pll_r_o}, "pllpin");
      chk(1, xtal_en_o, "xen");
      chk(1, ring_rdy_o, "rdy");
      $display("reset test done");
    end
  endtask

  task t_div;
    begin
      apb(1, 8'h00, 32'h4000_0002, 1);
      chk(2, ring_div_o, "div");
      chk(0, ring_trim_o, "trim");
      per(3);
      apb(1, 8'h00, 32'h401F_0000, 1);
      chk(31, ring_trim_o, "trim");
      repeat (5) @(posedge clk_i);
      per(1);
      $display("divider test done");
    end
  endtask

  task t_en;
    begin
      apb(1, 8'h08, 32'h0007_0DF1, 1);
      repeat (2) @(posedge clk_i);
      chk(1, fast_src_pll_o, "fast");
      chk(0, core_src_ring_o, "core");
      apb(1, 8'h00, 32'h3FFF_FFFF, 1);
      repeat (3) @(posedge clk_i);
      apb(0, 8'h00, 0, 1); chk(32'h001F_003F, rd, "ring");
      chk(0, ring_en_o, "en");
      apb(1, 8'h00, 32'h4000_0004, 1);
      apb(0, 8'h00, 0, 1); chk(32'h4000_0004, rd, "ring");
      repeat (20) @(posedge clk_i);
      apb(0, 8'h00, 0, 1); chk(32'hC000_0004, rd, "ring");
      apb(1, 8'h08, 32'h0006_0DF1, 1);
      $display("enable test done");
    end
  endtask

  task t_bus;
    begin
      apb(1, 8'h00, 32'h4000_0000, 0); chk(1, er, "err");
      apb(0, 8'h00, 0, 1); chk(32'hC000_0004, rd, "ring");
      apb(1, 8'h10, 32'h4000_0000, 1); chk(1, er, "err");
      apb(0, 8'h10, 0, 1); chk(0, rd, "unmap");
      chk(1, er, "err");
      apb(1, 8'hF0, 32'h1234_5678, 1); chk(32'h1234_5678, procmon_o, "pmon");
      pll_lock_i <= 1;
      xtal_rdy_i <= 1;
      rtc_ext_sel_i <= 1;
      repeat (4) @(posedge clk_i);
      chk(1, rtc_src_ext_o, "rtc");
      apb(0, 8'h08, 0, 1); chk(32'h8006_0DF1, rd, "pll");
      apb(0, 8'h04, 0, 1); chk(32'hC000_0000, rd, "xtal");
      apb(1, 8'h0C, 32'hFFFF_FFE5, 1); chk(32'h0000_0025, pll_out_div_o, "odivp");
      apb(0, 8'h0C, 0, 1); chk(32'h0000_0025, rd, "odiv");
      apb(1, 8'h04, 32'h0000_0000, 1); chk(0, xtal_en_o, "xen");
      apb(0, 8'h04, 0, 1); chk(0, rd, "xtal");
      $display("bus test done");
    end
  endtask

  task t_rst2;
    begin
      apb(1, 8'h00, 32'h0000_0004, 1);
      rst_i <= 1;
      repeat (3) @(posedge clk_i);
      rst_i <= 0;
      @(negedge clk_i);
      chk(1, ring_en_o, "en");
      apb(0, 8'h00, 0, 1); chk(32'h4010_0004, rd, "ring");
      repeat (20) @(posedge clk_i);
      apb(0, 8'h00, 0, 1); chk(32'hC010_0004, rd, "ring");
      $display("second reset test done");
    end
  endtask

  // main sequence
  initial
  begin
    {psel_i, penable_i, pwrite_i, xtal_rdy_i, pll_lock_i, rtc_ext_sel_i} = 0;
    paddr_i = 0;
    pwdata_i = 0;
    pprot_i = 1;
    rst_i = 1;
    failures = 0;
    checked = 0;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    t_reset;
    t_div;
    t_en;
    t_bus;
    t_rst2;
    finish_test;
  end
endmodule // ring_oscillator_clock_control_test

// ---- sim/rocc_checker.sv ----
`timescale 1ns/1ns
// ****************
// bus and ring checks
// ****************
module rocc_checker
(
  input wire        clk_i,
  input wire        rst_i,
  input wire        psel_i,
  input wire        penable_i,
  input wire        pwrite_i,
  input wire        pprot_i,
  input wire [31:0] prdata_o,
  input wire        pready_o,
  input wire        pslverr_o,
  input wire [4:0]  ring_trim_o,
  input wire        ring_en_o,
  input wire [5:0]  ring_div_o,
  input wire        ring_tick_o,
  input wire        ring_rdy_o,
  input wire        fast_src_pll_o,
  input wire        core_src_ring_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // access phase still waiting for its answer
  sequence s_acc;
    psel_i && penable_i && !pready_o;
  endsequence
  // ring stays not ready for a while, then comes up
  sequence s_wake;
    !ring_rdy_o [*8] ##[8:12] ring_rdy_o;
  endsequence
  a_one_wait: assert property (s_acc |=> pready_o)
    else $error("no answer one cycle after access");
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("pready held too long");
  a_priv_refuse: assert property (s_acc ##0 !pprot_i |=> pslverr_o)
    else $error("unprivileged access not refused");
  a_err_rdata: assert property (pready_o && pslverr_o && !pwrite_i |-> prdata_o == 32'h0000_0000)
    else $error("refused read returned data");
  a_core_follow: assert property (core_src_ring_o == !$past(fast_src_pll_o))
    else $error("core source not following select");
  a_wake_time: assert property ($rose(ring_en_o) |=> s_wake)
    else $error("ring ready timing wrong");
  a_stop_clears: assert property ($fell(ring_en_o) |-> ##[1:2] !ring_rdy_o ##1 !ring_rdy_o)
    else $error("ready stayed up while disabled");
  a_tick_space: assert property (ring_tick_o && $stable(ring_div_o) && ring_div_o != 6'h00
    |=> !ring_tick_o)
    else $error("ticks too close");
  a_reset_load: assert property ($fell(rst_i) |-> ring_trim_o == 5'h10 && ring_div_o == 6'h04
    && ring_en_o && !fast_src_pll_o)
    else $error("reset values wrong");
endmodule // rocc_checker

bind rocc_top rocc_checker u_chk
(
  .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .pprot_i(pprot_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .ring_trim_o(ring_trim_o), .ring_en_o(ring_en_o), .ring_div_o(ring_div_o),
  .ring_tick_o(ring_tick_o), .ring_rdy_o(ring_rdy_o), .fast_src_pll_o(fast_src_pll_o),
  .core_src_ring_o(core_src_ring_o)
);
